// >>> src/bcdalu_core.sv
// Decimal-adjust and decrement-file execution datapath with its own data memory.
// Assumes an APB master on pclk; instructions are written into the instruction register.
//
// Summary of operation
// - Adjust accumulator nibbles by six; only carry changes.
// - Decrement file value; update carry, outflow, sign, range, zero.
// - Destination bit picks accumulator or file register.
// - Bank bit zero uses access bank.
// - Bank bit one uses bank select register.
// - Extended mode low addresses with bank bit zero use indexed offset.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module bcdalu_core #(
    parameter int ADDR_W = 12
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    localparam int BANK_W = ADDR_W - 8;

    if (ADDR_W < 9 || ADDR_W > 16) begin : g_bad_addr_w
        $error("ADDR_W must be 9 to 16.");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus decode.
    bcdalu_pkg::bcdalu_phase_t phase;
    bcdalu_pkg::bcdalu_kind_t  kind;
    bcdalu_pkg::bcdalu_flags_t flags;
    logic [7:0]        mem [2**ADDR_W];
    logic [15:0]       instr;
    logic [7:0]        acc;
    logic [BANK_W-1:0] bank_select_register;
    logic              ext_en;
    logic [ADDR_W-1:0] index_base;
    logic [ADDR_W-1:0] mem_ptr;
    logic              illegal;
    logic [ADDR_W-1:0] opnd_addr;
    logic [7:0]        operand;
    logic [7:0]        result;
    bcdalu_pkg::bcdalu_flags_t res_flags;

    wire       access  = psel && penable;
    wire       busy    = phase != bcdalu_pkg::PH_IDLE;
    wire [7:0] reg_off = paddr[7:0];
    wire       mapped  = paddr[31:8] == 24'h000000 && reg_off <= bcdalu_pkg::ADDR_STATE
                         && reg_off[1:0] == 2'h0;
    wire       wr_ok   = access && pwrite && mapped && !busy;
    wire       wr_ins  = wr_ok && reg_off == bcdalu_pkg::ADDR_INSTR;
    wire       wr_acc  = wr_ok && reg_off == bcdalu_pkg::ADDR_ACC;
    wire       wr_flg  = wr_ok && reg_off == bcdalu_pkg::ADDR_FLAGS;
    wire       wr_bank = wr_ok && reg_off == bcdalu_pkg::ADDR_BANK;
    wire       wr_cfg  = wr_ok && reg_off == bcdalu_pkg::ADDR_CFG;
    wire       wr_idx  = wr_ok && reg_off == bcdalu_pkg::ADDR_INDEX;
    wire       wr_mptr = wr_ok && reg_off == bcdalu_pkg::ADDR_MEMADDR;
    wire       wr_mdat = wr_ok && reg_off == bcdalu_pkg::ADDR_MEMDATA;

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    logic [31:0] rd_value;
    wire         rd_setup    = psel && !penable && !pwrite;
    wire  [31:0] next_prdata = rd_setup ? rd_value : (access ? prdata : 32'h00000000);

    // Read data is captured at the end of the setup cycle and stands through the access cycle.
    always_comb begin
        rd_value = 32'h00000000;
        case (reg_off)
            bcdalu_pkg::ADDR_INSTR:   rd_value = {16'h0000, instr};
            bcdalu_pkg::ADDR_ACC:     rd_value = {24'h000000, acc};
            bcdalu_pkg::ADDR_FLAGS:   rd_value = {27'h0000000, flags};
            bcdalu_pkg::ADDR_BANK:    rd_value = {{(32-BANK_W){1'b0}}, bank_select_register};
            bcdalu_pkg::ADDR_CFG:     rd_value = {31'h00000000, ext_en};
            bcdalu_pkg::ADDR_INDEX:   rd_value = {{(32-ADDR_W){1'b0}}, index_base};
            bcdalu_pkg::ADDR_MEMADDR: rd_value = {{(32-ADDR_W){1'b0}}, mem_ptr};
            bcdalu_pkg::ADDR_MEMDATA: rd_value = {24'h000000, mem[mem_ptr]};
            bcdalu_pkg::ADDR_STATE:   rd_value = {30'h00000000, illegal, busy};
            default:                  rd_value = 32'h00000000;
        endcase
        if (!mapped) begin
            rd_value = 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction decode and operand address.
    wire       is_adjust    = instr == bcdalu_pkg::OP_ADJUST;
    wire       is_decrement = instr[15:10] == bcdalu_pkg::OP_DEC_TOP;
    wire       legal_op     = is_adjust || is_decrement;
    wire       dest_f  = instr[bcdalu_pkg::OP_D_BIT];
    wire       bank_a  = instr[bcdalu_pkg::OP_A_BIT];
    wire [7:0] f_field = instr[7:0];
    wire       low_f   = f_field <= bcdalu_pkg::ACCESS_LIMIT;
    wire [ADDR_W-1:0] addr_banked  = {bank_select_register, f_field};
    wire [ADDR_W-1:0] addr_access  = {{BANK_W{!low_f}}, f_field};
    wire [ADDR_W-1:0] addr_indexed = index_base + {{BANK_W{1'b0}}, f_field};
    wire [ADDR_W-1:0] next_addr    = bank_a ? addr_banked :
                                     (ext_en && low_f) ? addr_indexed : addr_access;

    ////////////////////////////////////////////////////////////////////////////////
    // Processing: decimal adjust and decrement.
    wire       adj_lo   = operand[3:0] > bcdalu_pkg::BCD_MAX || flags.low_nibble_outflow;
    wire [8:0] adj_mid  = {1'b0, operand} + {1'b0, adj_lo ? bcdalu_pkg::BCD_FIX_LO : 8'h00};
    wire       adj_hi   = adj_mid[7:4] > bcdalu_pkg::BCD_MAX || flags.carry || adj_mid[8];
    wire [7:0] adj_res  = adj_mid[7:0] + (adj_hi ? bcdalu_pkg::BCD_FIX_HI : 8'h00);
    wire [7:0] dec_res  = operand - 8'h01;

    always_comb begin
        res_flags = flags;
        result    = adj_res;
        if (kind == bcdalu_pkg::KIND_ADJUST) begin
            res_flags.carry = flags.carry || adj_hi;
        end else begin
            result                       = dec_res;
            res_flags.carry              = operand != 8'h00;
            res_flags.low_nibble_outflow = operand[3:0] != 4'h0;
            res_flags.zero               = dec_res == 8'h00;
            res_flags.signed_range_flag  = operand == bcdalu_pkg::SIGNED_MIN;
            res_flags.negative           = dec_res[7];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Phase sequencer and state.
    logic [7:0]                result_q;
    bcdalu_pkg::bcdalu_flags_t res_flags_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= bcdalu_pkg::PH_IDLE;
            kind  <= bcdalu_pkg::KIND_NONE;
        end else begin
            case (phase)
                bcdalu_pkg::PH_IDLE:    phase <= wr_ins ? bcdalu_pkg::PH_DECODE
                                                        : bcdalu_pkg::PH_IDLE;
                bcdalu_pkg::PH_DECODE: begin
                    phase <= legal_op ? bcdalu_pkg::PH_READ : bcdalu_pkg::PH_IDLE;
                    kind  <= is_adjust ? bcdalu_pkg::KIND_ADJUST : bcdalu_pkg::KIND_DEC;
                end
                bcdalu_pkg::PH_READ:    phase <= bcdalu_pkg::PH_PROCESS;
                bcdalu_pkg::PH_PROCESS: phase <= bcdalu_pkg::PH_WRITE;
                bcdalu_pkg::PH_WRITE:   phase <= bcdalu_pkg::PH_IDLE;
                default:                phase <= bcdalu_pkg::PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr                <= 16'h0000;
            illegal              <= 1'b0;
            bank_select_register <= '0;
            ext_en               <= 1'b0;
            index_base           <= '0;
            mem_ptr              <= '0;
            opnd_addr            <= '0;
            operand              <= 8'h00;
            result_q             <= 8'h00;
            res_flags_q          <= bcdalu_pkg::FLAGS_RESET;
        end else begin
            if (wr_ins) begin
                instr   <= pwdata[15:0];
                illegal <= 1'b0;
            end
            if (phase == bcdalu_pkg::PH_DECODE) begin
                illegal   <= !legal_op;
                opnd_addr <= next_addr;
            end
            if (phase == bcdalu_pkg::PH_READ) begin
                operand <= (kind == bcdalu_pkg::KIND_ADJUST) ? acc : mem[opnd_addr];
            end
            if (phase == bcdalu_pkg::PH_PROCESS) begin
                result_q    <= result;
                res_flags_q <= res_flags;
            end
            if (wr_bank) bank_select_register <= pwdata[BANK_W-1:0];
            if (wr_cfg)  ext_en               <= pwdata[bcdalu_pkg::CFG_EXT_BIT];
            if (wr_idx)  index_base           <= pwdata[ADDR_W-1:0];
            if (wr_mptr) mem_ptr              <= pwdata[ADDR_W-1:0];
        end
    end

    wire wb       = phase == bcdalu_pkg::PH_WRITE;
    wire wb_mem   = wb && kind == bcdalu_pkg::KIND_DEC && dest_f;
    wire wb_acc   = wb && !wb_mem;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc   <= bcdalu_pkg::ACC_RESET;
            flags <= bcdalu_pkg::FLAGS_RESET;
        end else begin
            if (wr_acc) acc   <= pwdata[7:0];
            if (wr_flg) flags <= pwdata[4:0];
            if (wb_acc) acc   <= result_q;
            if (wb)     flags <= res_flags_q;
        end
    end

    always_ff @(posedge pclk) begin
        if (wr_mdat) mem[mem_ptr]   <= pwdata[7:0];
        if (wb_mem)  mem[opnd_addr] <= result_q;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_run;
        phase == bcdalu_pkg::PH_DECODE && legal_op ##1
        phase == bcdalu_pkg::PH_READ ##1 phase == bcdalu_pkg::PH_PROCESS;
    endsequence

    chk_adjust_flags_only: assert property (@(posedge pclk) disable iff (!presetn)
        wb && kind == bcdalu_pkg::KIND_ADJUST |=> flags[4:1] == $past(flags[4:1])
        && flags.carry == ($past(res_flags_q.carry)))
        else $error("Decimal adjust changed a flag other than carry.");
    chk_adjust_value: assert property (@(posedge pclk) disable iff (!presetn)
        phase == bcdalu_pkg::PH_READ && kind == bcdalu_pkg::KIND_ADJUST && !flags.carry
        && !flags.low_nibble_outflow && acc[3:0] <= bcdalu_pkg::BCD_MAX
        && acc[7:4] <= bcdalu_pkg::BCD_MAX |=> ##2 acc == $past(acc, 3) && !flags.carry)
        else $error("Decimal adjust altered a valid packed value.");
    chk_decrement_result: assert property (@(posedge pclk) disable iff (!presetn)
        phase == bcdalu_pkg::PH_PROCESS && kind == bcdalu_pkg::KIND_DEC |=>
        result_q == operand - 8'h01 && res_flags_q.zero == (operand == 8'h01)
        && res_flags_q.carry == (operand != 8'h00))
        else $error("Decrement result or flags wrong.");
    chk_dest_select: assert property (@(posedge pclk) disable iff (!presetn)
        wb && kind == bcdalu_pkg::KIND_DEC && !dest_f |=> acc == $past(result_q))
        else $error("Decrement to accumulator lost its result.");
    chk_access_bank: assert property (@(posedge pclk) disable iff (!presetn)
        phase == bcdalu_pkg::PH_DECODE && is_decrement && !bank_a && !ext_en |=>
        opnd_addr == {{BANK_W{$past(f_field) > bcdalu_pkg::ACCESS_LIMIT}}, $past(f_field)})
        else $error("Access bank address wrong.");
    chk_banked_addr: assert property (@(posedge pclk) disable iff (!presetn)
        phase == bcdalu_pkg::PH_DECODE && is_decrement && bank_a |=>
        opnd_addr[ADDR_W-1:8] == $past(bank_select_register))
        else $error("Bank select not used for address.");
    chk_indexed_addr: assert property (@(posedge pclk) disable iff (!presetn)
        phase == bcdalu_pkg::PH_DECODE && is_decrement && !bank_a && ext_en && low_f |=>
        opnd_addr == $past(index_base) + {{BANK_W{1'b0}}, $past(f_field)})
        else $error("Indexed literal offset address wrong.");
    chk_four_phases: assert property (@(posedge pclk) disable iff (!presetn)
        s_run |=> wb ##1 phase == bcdalu_pkg::PH_IDLE)
        else $error("Instruction did not finish in four phases.");
endmodule : bcdalu_core

// >>> src/bcdalu_pkg.sv
// Constants, flag layout and phase states for the decimal-adjust and decrement datapath.
// Assumes a 32-bit APB master and one 25 MHz core clock.
package bcdalu_pkg;
    localparam logic [7:0]  ADDR_INSTR    = 8'h00;
    localparam logic [7:0]  ADDR_ACC      = 8'h04;
    localparam logic [7:0]  ADDR_FLAGS    = 8'h08;
    localparam logic [7:0]  ADDR_BANK     = 8'h0C;
    localparam logic [7:0]  ADDR_CFG      = 8'h10;
    localparam logic [7:0]  ADDR_INDEX    = 8'h14;
    localparam logic [7:0]  ADDR_MEMADDR  = 8'h18;
    localparam logic [7:0]  ADDR_MEMDATA  = 8'h1C;
    localparam logic [7:0]  ADDR_STATE    = 8'h20;
    localparam logic [15:0] OP_ADJUST     = 16'h0007;
    localparam logic [5:0]  OP_DEC_TOP    = 6'h01;
    localparam int          OP_D_BIT      = 9;
    localparam int          OP_A_BIT      = 8;
    localparam logic [7:0]  ACCESS_LIMIT  = 8'h5F;
    localparam logic [3:0]  BCD_MAX       = 4'h9;
    localparam logic [7:0]  BCD_FIX_LO    = 8'h06;
    localparam logic [7:0]  BCD_FIX_HI    = 8'h60;
    localparam logic [7:0]  SIGNED_MIN    = 8'h80;
    localparam logic [4:0]  FLAGS_RESET   = 5'h00;
    localparam logic [7:0]  ACC_RESET     = 8'h00;
    localparam int          CFG_EXT_BIT   = 0;
    localparam int          STATE_BUSY    = 0;
    localparam int          STATE_ILLEGAL = 1;

    // Flag order from bit 0: carry, low nibble outflow, zero, signed range, sign.
    typedef struct packed {
        logic negative;
        logic signed_range_flag;
        logic zero;
        logic low_nibble_outflow;
        logic carry;
    } bcdalu_flags_t;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_DECODE,
        PH_READ,
        PH_PROCESS,
        PH_WRITE
    } bcdalu_phase_t;

    typedef enum logic [1:0] {
        KIND_NONE,
        KIND_ADJUST,
        KIND_DEC
    } bcdalu_kind_t;
endpackage : bcdalu_pkg

// >>> test/bcdalu_apb_master.sv
// APB master model that stands in for the software side of the datapath.
// Assumes pclk from the bench and a slave that answers within 16 cycles.
`timescale 1ns/1ps
module bcdalu_apb_master (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             hung
);
    initial begin
        psel    = 1'h0;
        penable = 1'h0;
        pwrite  = 1'h0;
        paddr   = 32'h0;
        pwdata  = 32'h0;
        hung    = 1'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // One transfer; the request stands until pready is sampled high or 16 cycles pass.
    task automatic xfer(input logic we, input logic [31:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= we;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        hung = (pready !== 1'h1);
        rdata = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        pwdata  <= ~wdata;
    endtask : xfer
endmodule : bcdalu_apb_master

// >>> test/tb_bcd_adjust_and_decrement_alu.sv
// Self-checking bench for the decimal-adjust and decrement datapath.
// Assumes the APB master model and the core's register map in the package.
`timescale 1ns/1ps
module tb_bcd_adjust_and_decrement_alu;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    int          mismatches, checked;

    bcdalu_core i_bcdalu_core (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    bcdalu_apb_master i_bcdalu_apb_master (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hung());

    initial pclk = 1'h0;
    always #20 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        i_bcdalu_apb_master.xfer(we, {24'h000000, a}, d, q, err);
        if (i_bcdalu_apb_master.hung) begin
            mismatches++;
            test_done();
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        bus(1'h1, a, d, q, e);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        bus(1'h0, a, 32'h0, q, e);
        check(what, exp, q);
    endtask : rd_chk

    task automatic run(input logic [15:0] instr);
        logic [31:0] q;
        logic        e;
        wr(bcdalu_pkg::ADDR_INSTR, {16'h0000, instr});
        for (int n = 0; n < 20; n++) begin
            bus(1'h0, bcdalu_pkg::ADDR_STATE, 32'h0, q, e);
            if (q[bcdalu_pkg::STATE_BUSY] === 1'h0) return;
        end
        mismatches++;
        test_done();
    endtask : run
    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset;
        logic [31:0] q;
        logic        e;
        rd_chk("acc", bcdalu_pkg::ADDR_ACC, 32'h0);
        rd_chk("flags", bcdalu_pkg::ADDR_FLAGS, 32'h0);
        rd_chk("state", bcdalu_pkg::ADDR_STATE, 32'h0);
        bus(1'h0, 8'h24, 32'h0, q, e);
        check("unmapped error", 32'h1, {31'h0, e});
    endtask : test_reset

    task automatic test_adjust;
        logic [7:0] t [7][4] = '{'{8'hA5, 8'h00, 8'h05, 8'h01}, '{8'hCE, 8'h00, 8'h34, 8'h01},
                                 '{8'h12, 8'h04, 8'h12, 8'h04}, '{8'h9A, 8'h1E, 8'h00, 8'h1F},
                                 '{8'h12, 8'h02, 8'h18, 8'h02}, '{8'h23, 8'h01, 8'h83, 8'h01},
                                 '{8'hFA, 8'h00, 8'h60, 8'h01}};
        for (int i = 0; i < 7; i++) begin
            wr(bcdalu_pkg::ADDR_ACC, {24'h0, t[i][0]});
            wr(bcdalu_pkg::ADDR_FLAGS, {24'h0, t[i][1]});
            run(bcdalu_pkg::OP_ADJUST);
            rd_chk("adjust acc", bcdalu_pkg::ADDR_ACC, {24'h0, t[i][2]});
            rd_chk("adjust flags", bcdalu_pkg::ADDR_FLAGS, {24'h0, t[i][3]});
        end
    endtask : test_adjust

    task automatic test_illegal;
        wr(bcdalu_pkg::ADDR_ACC, 32'h5A);
        run(16'h0008);
        rd_chk("illegal state", bcdalu_pkg::ADDR_STATE, 32'h2);
        rd_chk("illegal acc", bcdalu_pkg::ADDR_ACC, 32'h5A);
    endtask : test_illegal

    task automatic dec_case(input logic [15:0] instr, input logic [3:0] bank,
                             input logic cfg, input logic [11:0] phys, input logic [7:0] v);
        bcdalu_pkg::bcdalu_flags_t f;
        logic [7:0]                r;
        logic                      d;
        r = v - 8'h01;
        d = instr[bcdalu_pkg::OP_D_BIT];
        f.carry = (v != 8'h00);
        f.low_nibble_outflow = (v[3:0] != 4'h0);
        f.signed_range_flag = (v == 8'h80);
        f.zero = (r == 8'h00);
        f.negative = r[7];
        wr(bcdalu_pkg::ADDR_BANK, {28'h0, bank});
        wr(bcdalu_pkg::ADDR_CFG, {31'h0, cfg});
        wr(bcdalu_pkg::ADDR_INDEX, 32'h300);
        wr(bcdalu_pkg::ADDR_ACC, 32'h55);
        wr(bcdalu_pkg::ADDR_MEMADDR, {20'h0, phys});
        wr(bcdalu_pkg::ADDR_MEMDATA, {24'h0, v});
        run(instr);
        rd_chk("dec flags", bcdalu_pkg::ADDR_FLAGS, {27'h0, f});
        rd_chk("dec acc", bcdalu_pkg::ADDR_ACC, {24'h0, d ? 8'h55 : r});
        rd_chk("dec file", bcdalu_pkg::ADDR_MEMDATA, {24'h0, d ? r : v});
    endtask : dec_case

    task automatic test_dec_dest;
        dec_case(16'h0410, 4'h3, 1'h0, 12'h010, 8'h80);
        dec_case(16'h0705, 4'h2, 1'h0, 12'h205, 8'h01);
    endtask : test_dec_dest

    task automatic test_dec_modes;
        dec_case(16'h06A0, 4'h5, 1'h0, 12'hFA0, 8'h00);
        dec_case(16'h045F, 4'h5, 1'h0, 12'h05F, 8'h7F);
        dec_case(16'h065F, 4'h5, 1'h1, 12'h35F, 8'h33);
        dec_case(16'h0660, 4'h5, 1'h1, 12'hF60, 8'h10);
    endtask : test_dec_modes
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mismatches = 0;
        checked = 0;
        presetn = 1'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        test_reset();
        test_adjust();
        test_dec_dest();
        test_dec_modes();
        test_illegal();
        test_done();
    end
endmodule : tb_bcd_adjust_and_decrement_alu
